// *** mdcc_pkg.sv ***
// shared constants, register map and types of the duplex and collision control
package mdcc_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    // one slot is 512 bit times at 10 Mb/s
    localparam int unsigned SLOT_TIME_NS = 51200;
    localparam int unsigned SLOT_CYCLES =
        (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] LATE_BYTES = 7'h40;
    localparam logic [3:0] RETRY_LIMIT = 4'hf;
    localparam logic [3:0] BACKOFF_LIMIT = 4'ha;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;

    // ------------------------------------------------------------------
    // register map (byte addresses) and bit positions
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
    localparam logic [4:0] ADDR_MAC_CTRL_THREE = 5'h04;
    localparam logic [4:0] ADDR_PHY_CTRL_ONE = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_FLAGS = 5'h10;
    localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h14;
    localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h18;
    localparam logic [4:0] ADDR_RETRY_COUNT = 5'h1c;

    localparam int unsigned BIT_TX_REQUEST = 3;
    localparam int unsigned BIT_RX_ENABLE = 2;
    localparam int unsigned BIT_MAC_DUPLEX = 0;
    localparam int unsigned BIT_PHY_DUPLEX = 8;
    localparam int unsigned BIT_TX_ABORTED = 1;
    localparam int unsigned BIT_MODE_MISMATCH = 3;
    localparam int unsigned BIT_MODE_FULL = 5;
    localparam int unsigned BIT_IRQ_TX_ERROR = 1;
    localparam int unsigned BIT_IRQ_TX_DONE = 3;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h0a;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DEFER = 4'h2,
        ST_XMIT = 4'h4,
        ST_BACKOFF = 4'h8
    } mdcc_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } mdcc_avl_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } mdcc_avl_rsp_t;

    typedef struct packed {
        mdcc_state_t st;
        logic [1:0] crs_sync;
        logic [1:0] col_sync;
        logic tx_request;
        logic rx_enable;
        logic mac_duplex;
        logic phy_duplex;
        logic tx_aborted;
        logic [7:0] irq_flags;
        logic [7:0] irq_enable;
        logic [3:0] retries;
        logic [6:0] bytes;
        logic [9:0] slots;
        logic [15:0] slot_cnt;
        logic [15:0] lfsr;
        logic ack;
        logic [31:0] rdata;
        logic restart;
    } mdcc_regs_t;

endpackage

// *** mdcc_top.sv ***
// duplex selection and half-duplex medium access control with its registers
// ------------------------------------------------------------------
// Overview of operation
// - duplex mode comes only from software bits, never from negotiation.
// - with both the mac and phy duplex bits clear the block is half duplex.
// - with both the mac and phy duplex bits set the block is full duplex.
// - disagreeing duplex bits give undefined behaviour (run as half duplex).
// - in half duplex a request waits for a quiet medium, then transmits.
// - an early collision keeps the transmit request set and raises no error.
// - an early collision starts a truncated binary exponential backoff.
// - after backoff the same frame restarts from its first byte.
// - a collision after 15 retries drops the frame and clears the request.
// - a transmit-aborted flag tells an abandoned frame from a sent one.
// - a collision after 64 bytes aborts the frame at once without retry.
// - in full duplex collisions and carrier are ignored.
// ------------------------------------------------------------------
module mdcc_top
    import mdcc_pkg::*;
#(
    parameter int unsigned SLOT_CYCLES_P = SLOT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire mdcc_avl_req_t avl_req,
    output mdcc_avl_rsp_t avl_rsp,
    input wire logic carrier_sense_pin,
    input wire logic collision_pin,
    input wire logic tx_byte_sent,
    input wire logic tx_frame_done,
    output logic tx_en,
    output logic tx_restart,
    output logic full_duplex_mode,
    output logic phy_duplex_out,
    output logic rx_enable_out,
    output logic irq
);

    // ------------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------------
    generate
        if (SLOT_CYCLES_P < 1 || SLOT_CYCLES_P > 65536) begin : g_bad
            $error("slot cycle count out of range");
        end
    endgenerate

    localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYCLES_P - 1);

    mdcc_regs_t s_q;
    mdcc_regs_t s_d;

    logic full;
    logic busy;
    logic coll;
    logic bus_req;
    logic wr_take;
    logic [31:0] rd_value;
    logic [7:0] wlo;

    // mismatched bits fall back to half duplex behaviour
    assign full = s_q.mac_duplex & s_q.phy_duplex;
    // the medium is only watched in half duplex
    assign busy = ~full & s_q.crs_sync[1];
    assign coll = ~full & s_q.col_sync[1];
    assign bus_req = avl_req.read | avl_req.write;
    assign wr_take = avl_req.write & s_q.ack;
    assign wlo = avl_req.writedata[7:0];

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [9:0] backoff_mask(input logic [3:0] n);
        logic [3:0] k;
        logic [10:0] m;
        k = (n > BACKOFF_LIMIT) ? BACKOFF_LIMIT : n;
        m = (11'h001 << k) - 11'h001;
        return m[9:0];
    endfunction

    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (avl_req.address)
            ADDR_CTRL_ONE: begin
                rd_value[BIT_TX_REQUEST] = s_q.tx_request;
                rd_value[BIT_RX_ENABLE] = s_q.rx_enable;
            end
            ADDR_MAC_CTRL_THREE: rd_value[BIT_MAC_DUPLEX] = s_q.mac_duplex;
            ADDR_PHY_CTRL_ONE: rd_value[BIT_PHY_DUPLEX] = s_q.phy_duplex;
            ADDR_STATUS: begin
                rd_value[BIT_TX_ABORTED] = s_q.tx_aborted;
                rd_value[BIT_MODE_MISMATCH] = s_q.mac_duplex ^ s_q.phy_duplex;
                rd_value[BIT_MODE_FULL] = full;
            end
            ADDR_IRQ_FLAGS: rd_value[7:0] = s_q.irq_flags;
            ADDR_IRQ_ENABLE: rd_value[7:0] = s_q.irq_enable;
            ADDR_RETRY_COUNT: rd_value[3:0] = s_q.retries;
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.crs_sync = {s_q.crs_sync[0], carrier_sense_pin};
        s_d.col_sync = {s_q.col_sync[0], collision_pin};
        s_d.lfsr = {s_q.lfsr[14:0], ^(s_q.lfsr & LFSR_TAPS)};
        s_d.restart = 1'b0;
        s_d.ack = 1'b0;

        // one wait cycle on every access keeps read data registered
        if (bus_req && !s_q.ack) begin
            s_d.ack = 1'b1;
            s_d.rdata = rd_value;
        end
        if (wr_take) begin
            unique case (avl_req.address)
                ADDR_CTRL_ONE: if (avl_req.byteenable[0]) begin
                    s_d.tx_request = wlo[BIT_TX_REQUEST];
                    s_d.rx_enable = wlo[BIT_RX_ENABLE];
                    if (wlo[BIT_TX_REQUEST]) begin
                        s_d.tx_aborted = 1'b0;
                    end
                end
                ADDR_MAC_CTRL_THREE: if (avl_req.byteenable[0]) begin
                    s_d.mac_duplex = wlo[BIT_MAC_DUPLEX];
                end
                ADDR_PHY_CTRL_ONE: if (avl_req.byteenable[1]) begin
                    s_d.phy_duplex = avl_req.writedata[BIT_PHY_DUPLEX];
                end
                ADDR_IRQ_CLEAR: if (avl_req.byteenable[0]) begin
                    s_d.irq_flags = s_q.irq_flags & ~wlo;
                end
                ADDR_IRQ_ENABLE: if (avl_req.byteenable[0]) begin
                    s_d.irq_enable = wlo & IRQ_IMPL_MASK;
                end
                default: s_d.irq_enable = s_d.irq_enable;
            endcase
        end

        // engine comes after the bus so hardware sets win over clears
        unique case (s_q.st)
            ST_IDLE: begin
                if (s_q.tx_request) begin
                    s_d.retries = 4'h0;
                    s_d.st = ST_DEFER;
                end
            end
            ST_DEFER: begin
                if (!s_q.tx_request) begin
                    s_d.st = ST_IDLE;
                end else if (!busy) begin
                    s_d.st = ST_XMIT;
                    s_d.restart = 1'b1;
                    s_d.bytes = 7'h00;
                end
            end
            ST_XMIT: begin
                if (tx_byte_sent && s_q.bytes != LATE_BYTES) begin
                    s_d.bytes = s_q.bytes + 7'h01;
                end
                if (coll) begin
                    if (s_q.bytes == LATE_BYTES ||
                        s_q.retries == RETRY_LIMIT) begin
                        s_d.tx_request = 1'b0;
                        s_d.tx_aborted = 1'b1;
                        s_d.irq_flags[BIT_IRQ_TX_ERROR] = 1'b1;
                        s_d.st = ST_IDLE;
                    end else begin
                        // request stays set, no error flag
                        s_d.retries = s_q.retries + 4'h1;
                        s_d.slots = s_q.lfsr[9:0] &
                            backoff_mask(s_q.retries + 4'h1);
                        s_d.slot_cnt = 16'h0000;
                        s_d.st = ST_BACKOFF;
                    end
                end else if (tx_frame_done) begin
                    s_d.tx_request = 1'b0;
                    s_d.irq_flags[BIT_IRQ_TX_DONE] = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_BACKOFF: begin
                if (s_q.slots == 10'h000) begin
                    s_d.st = ST_DEFER;
                end else if (s_q.slot_cnt == SLOT_LAST) begin
                    s_d.slot_cnt = 16'h0000;
                    s_d.slots = s_q.slots - 10'h001;
                end else begin
                    s_d.slot_cnt = s_q.slot_cnt + 16'h0001;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.lfsr <= LFSR_SEED;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign avl_rsp.readdata = s_q.rdata;
    assign avl_rsp.waitrequest = bus_req & ~s_q.ack;
    assign tx_en = (s_q.st == ST_XMIT);
    assign tx_restart = s_q.restart;
    assign full_duplex_mode = full;
    assign phy_duplex_out = s_q.phy_duplex;
    assign rx_enable_out = s_q.rx_enable;
    assign irq = |(s_q.irq_flags & s_q.irq_enable);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b || !ce);

    logic early_col;
    logic late_col;
    assign early_col = (s_q.st == ST_XMIT) && coll &&
        s_q.bytes != LATE_BYTES && s_q.retries != RETRY_LIMIT;
    assign late_col = (s_q.st == ST_XMIT) && coll && s_q.bytes == LATE_BYTES;

    sequence seq_early_col;
        early_col ##0 ce;
    endsequence
    sequence seq_in_backoff;
        s_q.st == ST_BACKOFF && s_q.tx_request &&
            !s_q.irq_flags[BIT_IRQ_TX_ERROR];
    endsequence

    chk_mode_half: assert property (
        (!s_q.mac_duplex && !s_q.phy_duplex && s_q.st == ST_XMIT &&
            s_q.col_sync[1]) |=> !tx_en)
        else $error("half duplex transmission ignored a collision");
    chk_mode_full: assert property (
        (s_q.mac_duplex && s_q.phy_duplex && s_q.st == ST_DEFER &&
            s_q.tx_request) |=> tx_en)
        else $error("full duplex request waited for the medium");
    chk_defer_busy: assert property (
        (s_q.st == ST_DEFER && busy) |=> !tx_restart && !tx_en)
        else $error("transmission started on a busy medium");
    chk_early_keep_req: assert property (
        (seq_early_col and !s_q.irq_flags[BIT_IRQ_TX_ERROR]) |=>
            seq_in_backoff)
        else $error("early collision dropped request or flagged error");
    chk_backoff_bound: assert property (
        (s_q.st == ST_BACKOFF && s_q.slots != 10'h000 &&
            s_q.slot_cnt == SLOT_LAST) |=>
            s_q.slots == $past(s_q.slots) - 10'h001)
        else $error("backoff slot count did not step");
    chk_backoff_range: assert property (
        early_col |=> s_q.slots <= backoff_mask(s_q.retries))
        else $error("backoff draw out of range");
    chk_restart_clean: assert property (
        tx_restart |-> tx_en && s_q.bytes == 7'h00 &&
            $past(s_q.st) == ST_DEFER)
        else $error("restart did not begin at the first byte");
    chk_retry_abort: assert property (
        (s_q.st == ST_XMIT && coll && s_q.retries == RETRY_LIMIT) |=>
            !s_q.tx_request && s_q.tx_aborted && s_q.st == ST_IDLE)
        else $error("retry limit did not abort the frame");
    chk_late_abort: assert property (
        late_col |=> s_q.st == ST_IDLE && s_q.tx_aborted &&
            s_q.irq_flags[BIT_IRQ_TX_ERROR] && !s_q.tx_request)
        else $error("late collision did not abort at once");
    chk_full_no_col: assert property (
        (full && s_q.st == ST_XMIT && !tx_frame_done) |=> s_q.st == ST_XMIT)
        else $error("full duplex transmission reacted to the medium");
    chk_irq_level: assert property (
        irq == ((s_q.irq_flags[BIT_IRQ_TX_ERROR] &&
            s_q.irq_enable[BIT_IRQ_TX_ERROR]) ||
            (s_q.irq_flags[BIT_IRQ_TX_DONE] &&
            s_q.irq_enable[BIT_IRQ_TX_DONE])))
        else $error("interrupt output does not follow flags");
    chk_enable_mask: assert property (
        (s_q.irq_enable & ~IRQ_IMPL_MASK) == 8'h00)
        else $error("unimplemented interrupt enable bit set");
    chk_err_source: assert property (
        $rose(s_q.irq_flags[BIT_IRQ_TX_ERROR]) |->
            $past(s_q.st) == ST_XMIT && $past(coll))
        else $error("error flag set without an abort");
    chk_abort_flags: assert property (
        $rose(s_q.tx_aborted) |->
            !s_q.tx_request && s_q.irq_flags[BIT_IRQ_TX_ERROR])
        else $error("abort left request or error flag wrong");

    // ------------------------------------------------------------------
    // engine checks
    // ------------------------------------------------------------------
    sequence seq_abort_seen;
        s_q.st == ST_XMIT && coll &&
            (s_q.bytes == LATE_BYTES || s_q.retries == RETRY_LIMIT);
    endsequence
    sequence seq_aborted;
        s_q.st == ST_IDLE && s_q.tx_aborted && !s_q.tx_request;
    endsequence

    chk_abort_steps: assert property (
        seq_abort_seen |=> seq_aborted ##1 s_q.st == ST_IDLE)
        else $error("abort did not settle in idle");
    chk_idle_to_defer: assert property (
        (s_q.st == ST_IDLE && s_q.tx_request) |=> s_q.st == ST_DEFER)
        else $error("transmit request not taken from idle");
    chk_defer_cancel: assert property (
        (s_q.st == ST_DEFER && !s_q.tx_request) |=> s_q.st == ST_IDLE)
        else $error("cancelled request left the engine busy");
    chk_done_clears: assert property (
        (s_q.st == ST_XMIT && !coll && tx_frame_done) |=>
            !s_q.tx_request && !s_q.tx_aborted && s_q.st == ST_IDLE)
        else $error("finished frame not reported as sent");
    chk_done_flag: assert property (
        (s_q.st == ST_XMIT && !coll && tx_frame_done) |=>
            s_q.irq_flags[BIT_IRQ_TX_DONE])
        else $error("finished frame raised no done flag");
    chk_aborted_hold: assert property (
        (s_q.tx_aborted && !wr_take) |=> s_q.tx_aborted)
        else $error("aborted flag dropped without a new request");
    chk_bytes_sat: assert property (
        s_q.bytes <= LATE_BYTES)
        else $error("byte count ran past the late collision point");
    chk_late_no_retry: assert property (
        late_col |=> s_q.retries == $past(s_q.retries))
        else $error("late collision counted as a retry");
    chk_retry_step: assert property (
        early_col |=> s_q.retries == $past(s_q.retries) + 4'h1)
        else $error("retry count did not step on an early collision");
    chk_backoff_cnt: assert property (
        s_q.st == ST_BACKOFF |-> s_q.slot_cnt <= SLOT_LAST)
        else $error("slot counter ran past the slot length");
    chk_backoff_exit: assert property (
        (s_q.st == ST_BACKOFF && s_q.slots == 10'h000) |=>
            s_q.st == ST_DEFER && !tx_en)
        else $error("backoff did not return to deferral");
    chk_restart_pulse: assert property (
        tx_restart |=> !tx_restart)
        else $error("restart pulse stood for more than a cycle");
    chk_xmit_entry: assert property (
        $rose(tx_en) |-> tx_restart)
        else $error("transmission began without a restart");
    chk_mode_hold: assert property (
        !wr_take |=> s_q.mac_duplex == $past(s_q.mac_duplex) &&
            s_q.phy_duplex == $past(s_q.phy_duplex))
        else $error("duplex bits changed without a register write");

    // ------------------------------------------------------------------
    // register bus checks
    // ------------------------------------------------------------------
    sequence seq_new_req;
        bus_req && !s_q.ack;
    endsequence
    sequence seq_answer;
        !avl_rsp.waitrequest && s_q.ack;
    endsequence

    chk_bus_answer: assert property (
        seq_new_req ##1 bus_req |-> seq_answer)
        else $error("bus request not answered after one wait cycle");
    chk_bus_ack_pulse: assert property (
        s_q.ack |=> !s_q.ack)
        else $error("bus acknowledge stood for more than a cycle");

endmodule

// *** mdcc_remote_node.sv ***
// remote node model: drives the carrier and collision pins of the medium
module mdcc_remote_node (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic talking,
    input wire logic local_tx,
    output logic carrier,
    output logic collision
);
    timeunit 1ns;
    timeprecision 1ns;

    // carrier follows the remote transmitter only; this node sends no
    // negotiation pulses, so duplex is set by hand on both ends
    assign carrier = talking;

    // a collision exists only while both ends drive the medium at once
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            collision <= 1'b0;
        end else begin
            collision <= talking & local_tx;
        end
    end
endmodule

// *** mdcc_top_test.sv ***
// self-checking bench of the duplex and collision control block
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, s); end end

module mdcc_top_test;
    import mdcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // short slots keep fifteen backoffs inside the run
    localparam int unsigned SLOTS = 4;
    logic clock, rst_b, ce, talking, tx_byte_sent, tx_frame_done;
    logic carrier_sense_pin, collision_pin, tx_en, tx_restart;
    logic full_duplex_mode, phy_duplex_out, rx_enable_out, irq;
    mdcc_avl_req_t avl_req;
    mdcc_avl_rsp_t avl_rsp;
    logic [31:0] rd;
    int n_fail, compares, restarts;
    // reference model of what software can see
    int m_req, m_rx, m_mac, m_phy, m_abort, m_flags, m_en;

    mdcc_top #(.SLOT_CYCLES_P(SLOTS)) i_mdcc_top (.clock(clock),
        .rst_b(rst_b), .ce(ce), .avl_req(avl_req), .avl_rsp(avl_rsp),
        .carrier_sense_pin(carrier_sense_pin), .collision_pin(collision_pin),
        .tx_byte_sent(tx_byte_sent), .tx_frame_done(tx_frame_done),
        .tx_en(tx_en), .tx_restart(tx_restart),
        .full_duplex_mode(full_duplex_mode), .phy_duplex_out(phy_duplex_out),
        .rx_enable_out(rx_enable_out), .irq(irq));

    mdcc_remote_node i_mdcc_remote_node (.clock(clock), .rst_b(rst_b),
        .talking(talking), .local_tx(tx_en), .carrier(carrier_sense_pin),
        .collision(collision_pin));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        if (tx_restart === 1'b1) begin
            restarts++;
            `CHK("tx_en at restart", 1'b1, tx_en)
        end
    end

    // ------------------------------------------------------------------
    // bus and checking tasks
    // ------------------------------------------------------------------
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        n_fail++;
        $display("[FAIL] %s expected done seen timeout", what);
        wrap_up();
    endtask

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        avl_req.read <= ~wr;
        avl_req.write <= wr;
        avl_req.address <= a;
        avl_req.writedata <= d;
        avl_req.byteenable <= 4'hf;
        do begin
            @(posedge clock);
            n++;
        end while (avl_rsp.waitrequest !== 1'b0 && n < 40);
        rd = avl_rsp.readdata;
        avl_req.read <= 1'b0;
        avl_req.write <= 1'b0;
        @(posedge clock);
        if (n >= 40) give_up("bus");
    endtask

    task automatic check_regs;
        bus(1'b0, ADDR_CTRL_ONE, 32'h0);
        `CHK("control", 32'(m_req * 8 + m_rx * 4), rd)
        bus(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status", 32'(m_abort * 2 + (m_mac ^ m_phy) * 8
            + (m_mac & m_phy) * 32), rd)
        bus(1'b0, ADDR_IRQ_FLAGS, 32'h0);
        `CHK("irq flags", 32'(m_flags), rd)
        `CHK("irq", logic'((m_flags & m_en) != 0), irq)
        `CHK("full mode", logic'(m_mac & m_phy), full_duplex_mode)
        `CHK("phy duplex", logic'(m_phy), phy_duplex_out)
        `CHK("rx enable", logic'(m_rx), rx_enable_out)
    endtask

    // cols collisions, then success unless an abort ends the frame first
    task automatic frame(input int cols, input bit late, input bit busy);
        int k, n, nb;
        restarts = 0;
        m_req = 1;
        m_abort = 0;
        talking <= busy;
        repeat (3) @(posedge clock);
        bus(1'b1, ADDR_CTRL_ONE, 32'(8 + m_rx * 4));
        if (busy) begin
            repeat (30) @(posedge clock);
            `CHK("deferred", 0, restarts)
            // a frozen block must not start even once the medium is free
            ce <= 1'b0;
            talking <= 1'b0;
            repeat (10) @(posedge clock);
            `CHK("frozen", 0, restarts)
            `CHK("frozen tx", 1'b0, tx_en)
            ce <= 1'b1;
        end
        for (k = 0; k <= cols; k++) begin
            n = 0;
            while (restarts <= k && n < 6000) begin
                @(posedge clock);
                n++;
            end
            if (n >= 6000) give_up("restart");
            nb = (k == cols) ? 1 + $urandom % 100
                : (late ? 64 : 1 + $urandom % 63);
            // in full duplex the remote talks over the frame unharmed
            talking <= logic'(k == cols && m_mac & m_phy);
            tx_byte_sent <= 1'b1;
            repeat (nb) @(posedge clock);
            tx_byte_sent <= 1'b0;
            if (k == cols) begin
                `CHK("tx held", 1'b1, tx_en)
                tx_frame_done <= 1'b1;
                @(posedge clock);
                tx_frame_done <= 1'b0;
                talking <= 1'b0;
                m_req = 0;
                m_flags |= 8;
                return;
            end
            talking <= 1'b1;
            n = 0;
            while (tx_en !== 1'b0 && n < 20) begin
                @(posedge clock);
                n++;
            end
            if (n >= 20) give_up("collision");
            talking <= 1'b0;
            if (late || k == 15) begin
                m_req = 0;
                m_abort = 1;
                m_flags |= 2;
                repeat (40) @(posedge clock);
                `CHK("no retry", k + 1, restarts)
                bus(1'b0, ADDR_RETRY_COUNT, 32'h0);
                `CHK("retries", 32'(late ? k : 15), rd)
                return;
            end
            check_regs();
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        talking = 1'b0;
        tx_byte_sent = 1'b0;
        tx_frame_done = 1'b0;
        avl_req = '0;
        {n_fail, compares, restarts} = '0;
        {m_req, m_rx, m_mac, m_phy, m_abort, m_flags, m_en} = '0;
        rd = $urandom(14);
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        check_regs();
        bus(1'b1, ADDR_IRQ_ENABLE, 32'hff);
        m_en = 10;
        bus(1'b0, ADDR_IRQ_ENABLE, 32'h0);
        `CHK("irq enable", 32'h0000000a, rd)
        m_rx = 1;
        bus(1'b1, ADDR_CTRL_ONE, 32'h4);
        frame(0, 1'b0, 1'b1);
        check_regs();
        bus(1'b1, ADDR_IRQ_CLEAR, 32'h8);
        m_flags = 0;
        frame(3, 1'b0, 1'b0);
        check_regs();
        frame(16, 1'b0, 1'b0);
        check_regs();
        // a set flag with its enable cleared keeps the line low
        bus(1'b1, ADDR_IRQ_ENABLE, 32'h0);
        m_en = 0;
        check_regs();
        bus(1'b1, ADDR_IRQ_CLEAR, 32'ha);
        m_flags = 0;
        m_en = 10;
        bus(1'b1, ADDR_IRQ_ENABLE, 32'ha);
        frame(1, 1'b1, 1'b0);
        check_regs();
        m_rx = 0;
        bus(1'b1, ADDR_CTRL_ONE, 32'h0);
        m_mac = 1;
        bus(1'b1, ADDR_MAC_CTRL_THREE, 32'h1);
        check_regs();
        m_phy = 1;
        bus(1'b1, ADDR_PHY_CTRL_ONE, 32'h100);
        check_regs();
        m_rx = 1;
        bus(1'b1, ADDR_CTRL_ONE, 32'h4);
        frame(0, 1'b0, 1'b0);
        check_regs();
        wrap_up();
    end
endmodule
